// ---- core/osc_pull_pkg.sv ----
// Purpose: Shared constants and types for the oscillator pull register bank
// Assumes: 16-bit registers at word addresses 0..2
// Notes: Pull range scale table holds half-range in units of 0.25 ppm
package osc_pull_pkg;
  localparam int ADDR_W = 2;
  localparam int DATA_W = 16;
  localparam int WORD_W = 26;
  localparam int LOW_W = 16;
  localparam int HIGH_W = 10;
  localparam int SEL_W = 4;
  localparam int SCALE_W = 14;
  localparam logic [ADDR_W-1:0] ADDR_LOWER = 2'h0;
  localparam logic [ADDR_W-1:0] ADDR_UPPER = 2'h1;
  localparam logic [ADDR_W-1:0] ADDR_RANGE = 2'h2;
  localparam int OE_BIT = 10;
  localparam logic [LOW_W-1:0] LOWER_RESET = 16'h0000;
  localparam logic [HIGH_W-1:0] UPPER_RESET = 10'h000;
  localparam logic OE_RESET = 1'b0;
  localparam logic [SEL_W-1:0] RANGE_DEFAULT = 4'h9;
  localparam logic [WORD_W-1:0] WORD_RESET = 26'h0000000;
  // Full-scale positive magnitude, 2^25-1
  localparam logic [WORD_W-1:0] FULL_SCALE = 26'h1ffffff;
  typedef enum logic [1:0] {ST_IDLE, ST_COMMIT} commit_state_t;
endpackage

// ---- core/reg_access_if.sv ----
// Purpose: Carries one register access between the bank and its decoder
// Assumes: Single-cycle write strobe
// Notes: None
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
  logic wr;
  logic [1:0] addr;
  logic [15:0] wdata;
  logic hit_lower;
  logic hit_upper;
  logic hit_range;
  modport decoder (input wr, addr, output hit_lower, hit_upper, hit_range);
  modport bank (input hit_lower, hit_upper, hit_range, output wr, addr, wdata);
endinterface
`default_nettype wire

// ---- core/addr_decoder.sv ----
// Purpose: Decodes a register write to per-register strobes
// Assumes: Address map from the package
// Notes: Combinational only
`timescale 1ns/1ps
`default_nettype none
module addr_decoder
  import osc_pull_pkg::*;
(
  reg_access_if.decoder acc
);
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
    hit = (a == target);
  endfunction
  assign acc.hit_lower = acc.wr && hit(acc.addr, ADDR_LOWER);
  assign acc.hit_upper = acc.wr && hit(acc.addr, ADDR_UPPER);
  assign acc.hit_range = acc.wr && hit(acc.addr, ADDR_RANGE);
endmodule
`default_nettype wire

// ---- core/range_scale.sv ----
// Purpose: Maps the pull range selector to its half-range magnitude
// Assumes: Sixteen ascending symmetric ranges
// Notes: Units are 0.25 ppm so 6.25 ppm is exact
`timescale 1ns/1ps
`default_nettype none
module range_scale
  import osc_pull_pkg::*;
(
  input wire logic [osc_pull_pkg::SEL_W-1:0] sel,
  output logic [osc_pull_pkg::SCALE_W-1:0] quarter_ppm
);
  always_comb begin
    case (sel)
      4'h0: quarter_ppm = 14'd25;
      4'h1: quarter_ppm = 14'd40;
      4'h2: quarter_ppm = 14'd50;
      4'h3: quarter_ppm = 14'd100;
      4'h4: quarter_ppm = 14'd200;
      4'h5: quarter_ppm = 14'd320;
      4'h6: quarter_ppm = 14'd400;
      4'h7: quarter_ppm = 14'd500;
      4'h8: quarter_ppm = 14'd600;
      4'h9: quarter_ppm = 14'd800;
      4'ha: quarter_ppm = 14'd1600;
      4'hb: quarter_ppm = 14'd2400;
      4'hc: quarter_ppm = 14'd3200;
      4'hd: quarter_ppm = 14'd4800;
      4'he: quarter_ppm = 14'd6400;
      default: quarter_ppm = 14'd12800;
    endcase
  end
endmodule
`default_nettype wire

// ---- core/osc_freq_pull_registers.sv ----
// Purpose: Register bank of a digitally tuned oscillator: offset word, output enable, pull range
// Assumes: Register port is synchronous to CLK; one write or read per cycle
// Notes: Offset is committed to the synthesis path only on an upper-half write
// What this block does
// - Lower 16 offset bits live read-write at word address zero.
// - Upper 10 offset bits live read-write in bits 9:0 at address one.
// - Committed 26-bit word is two's complement; sign sets pull direction.
// - Reset clears all 26 offset bits, giving nominal frequency.
// - Only an upper-half write commits the word; lower write alone changes only the stored lower half.
// - Bit 10 of address one is software output enable, default zero.
// - That bit acts only under software control; ignored under pin control.
// - Bits 15:11 of address one read zero and ignore writes.
// - Address two holds 4-bit range selector; bits 15:4 read zero.
// - Selector picks one of sixteen ascending ranges; default set at build, writable.
// - Full-scale positive word maps to the selected range's upper edge.
`timescale 1ns/1ps
`default_nettype none
module osc_freq_pull_registers
  import osc_pull_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CE,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [osc_pull_pkg::ADDR_W-1:0] ADDR,
  input wire logic [osc_pull_pkg::DATA_W-1:0] WDATA,
  input wire logic OE_SW_MODE,
  input wire logic OE_PIN,
  output logic [osc_pull_pkg::DATA_W-1:0] RDATA,
  output logic RDATA_VALID,
  output logic [osc_pull_pkg::WORD_W-1:0] PULL_OFFSET_WORD,
  output logic PULL_UPDATE,
  output logic [osc_pull_pkg::SEL_W-1:0] PULL_RANGE,
  output logic [osc_pull_pkg::SCALE_W-1:0] RANGE_QUARTER_PPM,
  output logic PULL_NEGATIVE,
  output logic OUTPUT_ENABLE
);
  import osc_pull_pkg::*;

  reg_access_if acc ();
  assign acc.wr = WR_EN && CE;
  assign acc.addr = ADDR;
  assign acc.wdata = WDATA;

  addr_decoder u_dec (
    .acc(acc)
  );

  logic [LOW_W-1:0] lower_offset_half;
  logic [HIGH_W-1:0] upper_offset_half;
  logic sw_oe;
  logic [SEL_W-1:0] range_sel;
  logic [WORD_W-1:0] pull_offset_word;
  logic update;
  logic [DATA_W-1:0] rdata;
  logic rvalid;
  logic oe_out;
  logic [SCALE_W-1:0] scale;
  logic [SCALE_W-1:0] next_scale_q;
  commit_state_t state;

  logic [LOW_W-1:0] next_lower;
  logic [HIGH_W-1:0] next_upper;
  logic next_sw_oe;
  logic [SEL_W-1:0] next_range;
  logic [WORD_W-1:0] next_word;
  logic next_update;
  logic [DATA_W-1:0] next_rdata;
  logic next_rvalid;
  logic next_oe_out;
  commit_state_t next_state;

  function automatic logic [DATA_W-1:0] read_mux(
    input logic [ADDR_W-1:0] a,
    input logic [LOW_W-1:0] lo,
    input logic [HIGH_W-1:0] hi,
    input logic oe,
    input logic [SEL_W-1:0] rs
  );
    case (a)
      ADDR_LOWER: read_mux = lo;
      ADDR_UPPER: read_mux = {5'h00, oe, hi};
      ADDR_RANGE: read_mux = {12'h000, rs};
      default: read_mux = 16'h0000;
    endcase
  endfunction

  range_scale u_scale (
    .sel(range_sel),
    .quarter_ppm(scale)
  );

  // Register file next values
  always_comb begin
    next_lower = lower_offset_half;
    next_upper = upper_offset_half;
    next_sw_oe = sw_oe;
    next_range = range_sel;
    next_word = pull_offset_word;
    next_update = 1'b0;
    next_state = ST_IDLE;
    if (acc.hit_lower) begin
      next_lower = acc.wdata;
    end
    if (acc.hit_upper) begin
      next_upper = acc.wdata[HIGH_W-1:0];
      if (OE_SW_MODE) begin
        next_sw_oe = acc.wdata[OE_BIT];
      end
      next_state = ST_COMMIT;
    end
    if (acc.hit_range) begin
      next_range = acc.wdata[SEL_W-1:0];
    end
    case (state)
      ST_IDLE: begin
        next_word = pull_offset_word;
      end
      ST_COMMIT: begin
        // Latch the pair only after the upper half has landed
        next_word = {upper_offset_half, lower_offset_half};
        next_update = 1'b1;
      end
      default: begin
        next_word = pull_offset_word;
      end
    endcase
  end

  // Read port and output enable next values
  always_comb begin
    next_rvalid = RD_EN;
    next_rdata = RD_EN ? read_mux(ADDR, lower_offset_half, upper_offset_half, sw_oe, range_sel) : 16'h0000;
    next_oe_out = OE_SW_MODE ? sw_oe : OE_PIN;
    next_scale_q = scale;
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      lower_offset_half <= LOWER_RESET;
      upper_offset_half <= UPPER_RESET;
      sw_oe <= OE_RESET;
      range_sel <= RANGE_DEFAULT;
      pull_offset_word <= WORD_RESET;
      update <= 1'b0;
      state <= ST_IDLE;
      rdata <= 16'h0000;
      rvalid <= 1'b0;
      oe_out <= 1'b0;
      RANGE_QUARTER_PPM <= 14'h0000;
    end else if (CE) begin
      lower_offset_half <= next_lower;
      upper_offset_half <= next_upper;
      sw_oe <= next_sw_oe;
      range_sel <= next_range;
      pull_offset_word <= next_word;
      update <= next_update;
      state <= next_state;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
      oe_out <= next_oe_out;
      RANGE_QUARTER_PPM <= next_scale_q;
    end
  end

  assign PULL_OFFSET_WORD = pull_offset_word;
  assign PULL_UPDATE = update;
  assign PULL_RANGE = range_sel;
  assign PULL_NEGATIVE = pull_offset_word[WORD_W-1];
  assign OUTPUT_ENABLE = oe_out;
  assign RDATA = rdata;
  assign RDATA_VALID = rvalid;

  // Checks
  property p_lower_no_commit;
    @(posedge CLK) disable iff (RESET)
    (CE && WR_EN && ADDR == ADDR_LOWER && !(state == ST_COMMIT)) |=> $stable(pull_offset_word);
  endproperty
  a_lower_no_commit: assert property (p_lower_no_commit) else $error("lower write changed word");

  property p_upper_commit;
    @(posedge CLK) disable iff (RESET)
    (CE && WR_EN && ADDR == ADDR_UPPER) ##1 CE |=>
      (pull_offset_word == {$past(upper_offset_half), $past(lower_offset_half)}) && update;
  endproperty
  a_upper_commit: assert property (p_upper_commit) else $error("upper write did not commit");

  property p_lower_store;
    @(posedge CLK) disable iff (RESET)
    (CE && WR_EN && ADDR == ADDR_LOWER) |=> lower_offset_half == $past(WDATA);
  endproperty
  a_lower_store: assert property (p_lower_store) else $error("lower half not stored");

  property p_reset_zero;
    @(posedge CLK) $past(RESET) |-> pull_offset_word == 26'h0000000 && !sw_oe;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset value wrong");

  property p_oe_hw_ignore;
    @(posedge CLK) disable iff (RESET)
    (CE && WR_EN && ADDR == ADDR_UPPER && !OE_SW_MODE) |=> sw_oe == $past(sw_oe);
  endproperty
  a_oe_hw_ignore: assert property (p_oe_hw_ignore) else $error("enable bit moved under pin control");

  property p_oe_sw;
    @(posedge CLK) disable iff (RESET)
    (CE && WR_EN && ADDR == ADDR_UPPER && OE_SW_MODE) ##1 (CE && OE_SW_MODE) |=> OUTPUT_ENABLE == $past(WDATA[OE_BIT], 2);
  endproperty
  a_oe_sw: assert property (p_oe_sw) else $error("software enable not applied");

  property p_upper_read_zero;
    @(posedge CLK) disable iff (RESET)
    (CE && RD_EN && ADDR == ADDR_UPPER) |=> RDATA[15:11] == 5'h00 && RDATA_VALID;
  endproperty
  a_upper_read_zero: assert property (p_upper_read_zero) else $error("unused upper bits not zero");

  property p_range_write;
    @(posedge CLK) disable iff (RESET)
    (CE && WR_EN && ADDR == ADDR_RANGE) |=> PULL_RANGE == $past(WDATA[3:0]);
  endproperty
  a_range_write: assert property (p_range_write) else $error("range not applied at once");

  property p_range_read;
    @(posedge CLK) disable iff (RESET)
    (CE && RD_EN && ADDR == ADDR_RANGE) |=> RDATA[15:4] == 12'h000 && RDATA[3:0] == $past(range_sel);
  endproperty
  a_range_read: assert property (p_range_read) else $error("range read wrong");

  property p_sign;
    @(posedge CLK) disable iff (RESET) PULL_NEGATIVE == (pull_offset_word > FULL_SCALE);
  endproperty
  a_sign: assert property (p_sign) else $error("sign wrong");

  property p_lower_keep;
    @(posedge CLK) disable iff (RESET)
    !(CE && WR_EN && ADDR == ADDR_LOWER) |=> $stable(lower_offset_half);
  endproperty
  a_lower_keep: assert property (p_lower_keep) else $error("lower half moved without a write");

  property p_upper_store;
    @(posedge CLK) disable iff (RESET)
    (CE && WR_EN && ADDR == ADDR_UPPER) |=> upper_offset_half == $past(WDATA[HIGH_W-1:0]);
  endproperty
  a_upper_store: assert property (p_upper_store) else $error("upper half not stored");

  property p_lower_read;
    @(posedge CLK) disable iff (RESET)
    (CE && RD_EN && ADDR == ADDR_LOWER) |=> RDATA == $past(lower_offset_half) && RDATA_VALID;
  endproperty
  a_lower_read: assert property (p_lower_read) else $error("lower half read wrong");

  property p_upper_read;
    @(posedge CLK) disable iff (RESET)
    (CE && RD_EN && ADDR == ADDR_UPPER) |=> RDATA[10:0] == {$past(sw_oe), $past(upper_offset_half)};
  endproperty
  a_upper_read: assert property (p_upper_read) else $error("upper half read wrong");

  property p_word_on_update;
    @(posedge CLK) disable iff (RESET)
    !$stable(pull_offset_word) |-> PULL_UPDATE;
  endproperty
  a_word_on_update: assert property (p_word_on_update) else $error("word moved without commit");

  property p_oe_pin;
    @(posedge CLK) disable iff (RESET)
    (CE && !OE_SW_MODE) |=> OUTPUT_ENABLE == $past(OE_PIN);
  endproperty
  a_oe_pin: assert property (p_oe_pin) else $error("enable does not follow pin");

  property p_range_keep;
    @(posedge CLK) disable iff (RESET)
    !(CE && WR_EN && ADDR == ADDR_RANGE) |=> $stable(range_sel);
  endproperty
  a_range_keep: assert property (p_range_keep) else $error("range moved without a write");

  property p_scale_narrow;
    @(posedge CLK) disable iff (RESET)
    (CE && range_sel == 4'h0) |=> RANGE_QUARTER_PPM == 14'h0019;
  endproperty
  a_scale_narrow: assert property (p_scale_narrow) else $error("narrowest range scale wrong");

  property p_scale_wide;
    @(posedge CLK) disable iff (RESET)
    (CE && range_sel == 4'hf) |=> RANGE_QUARTER_PPM == 14'h3200;
  endproperty
  a_scale_wide: assert property (p_scale_wide) else $error("widest range scale wrong");

  property p_ce_freeze;
    @(posedge CLK) disable iff (RESET)
    !CE |=> $stable(pull_offset_word) && $stable(upper_offset_half) && $stable(OUTPUT_ENABLE);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with enable low");

  c_commit: cover property (@(posedge CLK) disable iff (RESET) PULL_UPDATE);
  c_negative: cover property (@(posedge CLK) disable iff (RESET) PULL_UPDATE && PULL_NEGATIVE);
  c_range: cover property (@(posedge CLK) disable iff (RESET) CE && WR_EN && ADDR == ADDR_RANGE);
  c_pin_ignored: cover property (@(posedge CLK) disable iff (RESET) CE && WR_EN && ADDR == ADDR_UPPER && !OE_SW_MODE);
  c_read: cover property (@(posedge CLK) disable iff (RESET) RDATA_VALID);
endmodule
`default_nettype wire

// ---- test/host_model.sv ----
// Purpose: Register host driving the pull register bank
// Assumes: Accesses launched 1 ns after a rising edge
// Notes: Released address and data lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module host_model
  import osc_pull_pkg::*;
(
  input wire logic CLK,
  output logic CE,
  output logic WR_EN,
  output logic RD_EN,
  output logic [osc_pull_pkg::ADDR_W-1:0] ADDR,
  output logic [osc_pull_pkg::DATA_W-1:0] WDATA
);
  time last_commit = 0;
  initial begin
    CE = 1'b1;
    WR_EN = 1'b0;
    RD_EN = 1'b0;
    ADDR = 2'h0;
    WDATA = 16'h0000;
  end
  // Entered 1 ns after an edge; one access cycle, then one released cycle
  task automatic acc(input logic w, input logic r, input logic [1:0] a, input logic [15:0] d, input logic ce);
    if (w && ce && a == ADDR_UPPER) begin
      while ($time - last_commit < 26320) begin
        @(posedge CLK);
        #1;
      end
      last_commit = $time;
    end
    CE = ce;
    WR_EN = w;
    RD_EN = r;
    ADDR = a;
    WDATA = d;
    @(posedge CLK);
    #1;
    CE = 1'b1;
    WR_EN = 1'b0;
    RD_EN = 1'b0;
    ADDR = ~ADDR;
    WDATA = ~WDATA;
    @(posedge CLK);
    #1;
  endtask
endmodule
`default_nettype wire

// ---- test/osc_freq_pull_registers_bench.sv ----
// Purpose: Self-checking bench of the pull register bank
// Assumes: Host model drives the register port
// Notes: Reads and commits are noted in queues and checked by a monitor
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module osc_freq_pull_registers_bench;
  import osc_pull_pkg::*;
  logic CLK, RESET, CE, WR_EN, RD_EN, oe_sw_mode, oe_pin, rdata_valid, pull_update, pull_negative, output_enable;
  logic [1:0] addr;
  logic [15:0] wdata, rdata, re;
  logic [25:0] pull_offset_word, cw, ce_word, d;
  logic [3:0] pull_range, sel;
  logic [13:0] range_quarter_ppm;
  logic [13:0] quarter [16] = '{14'h0019, 14'h0028, 14'h0032, 14'h0064, 14'h00c8, 14'h0140, 14'h0190,
    14'h01f4, 14'h0258, 14'h0320, 14'h0640, 14'h0960, 14'h0c80, 14'h12c0, 14'h1900, 14'h3200};
  logic [15:0] lo;
  logic [9:0] hi;
  logic oe;
  logic [15:0] rq[$];
  logic [25:0] cq[$];
  int bad_count = 0;
  int comparisons = 0;
  host_model i_host_model (.CLK(CLK), .CE(CE), .WR_EN(WR_EN), .RD_EN(RD_EN), .ADDR(addr), .WDATA(wdata));
  osc_freq_pull_registers i_osc_freq_pull_registers (.CLK(CLK), .RESET(RESET), .CE(CE), .WR_EN(WR_EN),
    .RD_EN(RD_EN), .ADDR(addr), .WDATA(wdata), .OE_SW_MODE(oe_sw_mode), .OE_PIN(oe_pin), .RDATA(rdata),
    .RDATA_VALID(rdata_valid), .PULL_OFFSET_WORD(pull_offset_word), .PULL_UPDATE(pull_update),
    .PULL_RANGE(pull_range), .RANGE_QUARTER_PPM(range_quarter_ppm), .PULL_NEGATIVE(pull_negative),
    .OUTPUT_ENABLE(output_enable));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  function automatic logic [15:0] rd_val(input logic [1:0] a);
    case (a)
      2'h0: return lo;
      2'h1: return {5'h00, oe, hi};
      2'h2: return {12'h000, sel};
      default: return 16'h0000;
    endcase
  endfunction
  task automatic op(input logic w, input logic r, input logic [1:0] a, input logic [15:0] v, input logic c = 1'b1);
    if (r && c) rq.push_back(rd_val(a));
    if (w && c) begin
      case (a)
        2'h0: lo = v;
        2'h1: begin
          hi = v[9:0];
          if (oe_sw_mode) oe = v[10];
          cw = {hi, lo};
          cq.push_back(cw);
        end
        2'h2: sel = v[3:0];
        default: ;
      endcase
    end
    i_host_model.acc(w, r, a, v, c);
  endtask
  task automatic settle(input string name);
    repeat (3) @(posedge CLK);
    #1;
    `CHK("enable", oe_sw_mode ? oe : oe_pin, output_enable)
    `CHK("range", sel, pull_range)
    `CHK("scale", quarter[sel], range_quarter_ppm)
    `CHK("word", cw, pull_offset_word)
    $display("test %s done", name);
  endtask
  task test_done;
    $display("counts: %0d compared, %0d wrong", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(negedge CLK) begin
    if (rdata_valid === 1'b1) begin
      re = rq.size() ? rq.pop_front() : 16'hxxxx;
      `CHK("rdata", re, rdata)
    end
    if (pull_update === 1'b1) begin
      ce_word = cq.size() ? cq.pop_front() : 26'hxxxxxxx;
      `CHK("commit", ce_word, pull_offset_word)
      `CHK("sign", ce_word[25], pull_negative)
    end
  end
  initial begin
    #1ms;
    bad_count++;
    test_done();
  end
  initial begin
    RESET = 1'b1;
    oe_sw_mode = 1'b1;
    oe_pin = 1'b0;
    {lo, hi, oe, cw} = '0;
    sel = RANGE_DEFAULT;
    void'($urandom(23981));
    repeat (20) @(posedge CLK);
    #1 RESET = 1'b0;
    for (int a = 0; a < 4; a++) op(1'b0, 1'b1, a[1:0], 16'h0000);
    settle("reset");
    op(1'b1, 1'b0, 2'h0, 16'($urandom));
    op(1'b1, 1'b0, 2'h1, 16'($urandom), 1'b0);
    op(1'b0, 1'b1, 2'h0, 16'h0000);
    settle("lower only");
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 26'h1ffffff : (i == 1) ? 26'h2000000 : 26'($urandom);
      op(1'b1, 1'b0, 2'h0, d[15:0]);
      op(1'b1, 1'b1, 2'h1, {6'($urandom), d[25:16]});
      op(1'b0, 1'b1, 2'h1, 16'h0000);
      settle("commit");
    end
    oe_sw_mode = 1'b0;
    for (int p = 0; p < 2; p++) begin
      oe_pin = p[0];
      op(1'b1, 1'b0, 2'h1, {5'h1f, ~oe, hi});
      op(1'b0, 1'b1, 2'h1, 16'h0000);
      settle("pin control");
    end
    oe_sw_mode = 1'b1;
    for (int s = 0; s < 16; s++) begin
      op(1'b1, 1'b0, 2'h2, {12'($urandom), s[3:0]});
      op(1'b0, 1'b1, 2'h2, 16'h0000);
      settle("range");
    end
    op(1'b1, 1'b0, 2'h3, 16'($urandom));
    op(1'b0, 1'b1, 2'h3, 16'h0000);
    settle("unmapped");
    `CHK("notes left", 0, rq.size() + cq.size())
    test_done();
  end
endmodule
`default_nettype wire
